//--- hw/cpu_bus_cycle_ctrl.sv
// cpu_bus_cycle_ctrl: external bus cycle sequencer with its request fifo.
// assumes chipset pins arrive asynchronously and the core shares CLK_SYS.
// How it works
// - line write-back runs as a four-beat 64-bit burst with cacheable asserted
// - cache enable and policy inputs are never sampled during burst writes
// - first burst write data and parity are valid in the second clock
// - each sampled burst ready moves the next beat's data out one clock later
// - data holds while burst ready stays negated
// - burst writes start line aligned and run ascending
// - at least four idle clocks separate back-to-back burst writes, never pipelined
// - at most two cycles outstanding; locked and burst writes never pipelined
// - next address request sampled in every data, pipelined and turnaround clock
// - cache inputs sampled at next address request or first burst ready
// - a pipelined address comes at least two clocks after the request
// - next address request is latched and ignored until the cycle ends
// - direction change between pipelined cycles inserts one floating clock
// - interrupt gives two locked acknowledges; vector from low byte of second
// - acknowledges drive selects low, addresses 4 then 0, idle clock between
// - management interrupt enters mode at a boundary after writes drain
// - management interrupt three clocks before ready traps an I/O cycle that also has code select set
// - purge request is latched, write-backs run, then an acknowledge cycle
// - write buffer not empty blocks cache writes until seen empty again
// - hold request: finish cycles, float bus, grant until request drops
// - burst ready sampled from second clock each clock until seen
// - back-off floats the bus next clock and restarts the cycle later
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// request fifo with look-ahead of every held entry
// ----------------------------------------------------------------------
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DEPTH-1:0][WIDTH-1:0] look,
  output logic [CW-1:0] count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
  } fifo_type;
  fifo_type q;
  fifo_type d;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] wrap(input int v);
    return PW'(v % DEPTH);
  endfunction : wrap

  // full and empty come straight from the count
  assign in_ready = int'(q.cnt) < DEPTH;
  assign out_valid = q.cnt != '0;
  assign push = in_valid && in_ready;
  assign pop = out_ready && out_valid;
  assign count = q.cnt;

  always_comb begin
    d = q;
    for (int i = 0; i < DEPTH; i++) begin
      look[i] = q.mem[wrap(int'(q.rd) + i)];
    end
    if (push) begin
      d.mem[wrap(int'(q.rd) + int'(q.cnt))] = in_data;
    end
    if (pop) begin
      d.rd = wrap(int'(q.rd) + 1);
    end
    d.cnt = CW'(int'(q.cnt) + int'(push) - int'(pop));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : req_fifo

// ----------------------------------------------------------------------
// bus cycle controller
// ----------------------------------------------------------------------
module cpu_bus_cycle_ctrl #(
  parameter int FIFO_DEPTH = bus_cycle_pkg::FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire bus_cycle_pkg::req_type REQ,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic INSTR_BOUNDARY,
  input wire logic RESUME_DONE,
  input wire logic PURGE_WB_DONE,
  output logic [63:0] RD_DATA,
  output logic RD_VALID,
  output logic RD_CACHEABLE,
  output logic RD_WRITEBACK,
  output logic PARITY_ERR,
  output logic [7:0] VECTOR,
  output logic VECTOR_VALID,
  output logic IO_TRAP,
  output logic MGMT_ENTER,
  output logic PURGE_ACTIVE,
  output logic CACHE_WR_ALLOW,
  output logic [31:0] ADDR_OUT,
  output logic ADS_N,
  output logic MEM_IO_SEL,
  output logic DATA_CODE_SEL,
  output logic WRITE_READ_SEL,
  output logic CACHEABLE_OUT_N,
  output logic LOCK_N,
  output logic BUS_OE_N,
  output logic [63:0] DATA_OUT,
  output logic [7:0] DATA_PAR_OUT,
  output logic DATA_OE_N,
  input wire logic [63:0] DATA_IN,
  input wire logic [7:0] DATA_PAR_IN,
  input wire logic BURST_READY_IN_N,
  input wire logic NEXT_ADDR_REQ_N,
  input wire logic CACHE_ENABLE_IN_N,
  input wire logic WRITEBACK_POLICY_IN,
  input wire logic MASKABLE_IRQ_IN,
  input wire logic MGMT_IRQ_IN_N,
  output logic MGMT_MODE_ACTIVE_N,
  input wire logic EXT_WBUF_EMPTY_N,
  input wire logic HOLD_REQ_IN,
  output logic HOLD_GRANT_OUT,
  input wire logic BACKOFF_IN_N,
  input wire logic CACHE_PURGE_REQ_N
);
  localparam int RW = $bits(bus_cycle_pkg::req_type);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  bus_cycle_pkg::ctl_type q;
  bus_cycle_pkg::ctl_type d;
  bus_cycle_pkg::pin_type pin;
  bus_cycle_pkg::req_type hd [FIFO_DEPTH];
  logic [FIFO_DEPTH-1:0][RW-1:0] look;
  logic [CW-1:0] fifo_cnt;
  logic fifo_valid;
  logic pop;
  logic done;
  logic go;
  bus_cycle_pkg::cyc_type iss;

  // even parity per byte lane, for driven and for checked data
  function automatic logic [7:0] par8(input logic [63:0] v);
    logic [7:0] p;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^v[8*i +: 8];
    end
    return p;
  endfunction : par8

  // ------------------------------------------------------------------
  // request path
  // ------------------------------------------------------------------
  req_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .in_data(REQ),
    .in_valid(REQ_VALID),
    .in_ready(REQ_READY),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .look(look),
    .count(fifo_cnt)
  );

  // normalise pin polarity before the two synchroniser stages
  assign pin = '{burst_ready_in: !BURST_READY_IN_N, na: !NEXT_ADDR_REQ_N,
                 ken: !CACHE_ENABLE_IN_N, wb: WRITEBACK_POLICY_IN,
                 irq: MASKABLE_IRQ_IN, smi: !MGMT_IRQ_IN_N,
                 ext_wbuf_empty: !EXT_WBUF_EMPTY_N, hold: HOLD_REQ_IN,
                 backoff_in: !BACKOFF_IN_N, purge: !CACHE_PURGE_REQ_N,
                 data: DATA_IN, par: DATA_PAR_IN};

  // cycle ends on the last sampled ready; back-off cancels that ready
  assign done = q.st == bus_cycle_pkg::ST_DATA && q.s2.burst_ready_in && !q.s2.backoff_in
    && (!q.cur.burst || q.beat == bus_cycle_pkg::LAST_BEAT);
  // burst entries leave the fifo only after the whole line is accepted,
  // so a back-off restart can still replay every beat
  assign pop = (done && q.cur.fifo) || q.drain != 2'h0;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    go = 1'b0;
    iss = q.cur;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      hd[i] = bus_cycle_pkg::req_type'(look[i]);
    end
    d.s1 = pin;
    d.s2 = q.s1;
    d.ads = 1'b0;
    d.rvalid = 1'b0;
    d.vvalid = 1'b0;
    d.perr = 1'b0;
    d.trap = 1'b0;
    d.enter = 1'b0;
    // requests are latched; a new one wins over its own clear
    d.smi_lat = q.smi_lat || q.s2.smi;
    d.purge_lat = q.purge_lat || q.s2.purge;
    d.purge_wbd = q.purge_wbd || PURGE_WB_DONE;
    if (q.s2.smi && q.smi_cnt != bus_cycle_pkg::SMI_TRAP_CLKS) begin
      d.smi_cnt = q.smi_cnt + 2'h1;
    end else if (!q.s2.smi) begin
      d.smi_cnt = 2'h0;
    end
    if (RESUME_DONE) begin
      d.smm = 1'b0;
    end
    if (q.blk && q.s2.ext_wbuf_empty) begin
      d.blk = 1'b0;
    end
    if (q.drain != 2'h0) begin
      d.drain = q.drain - 2'h1;
    end
    // next address request: latched once, then ignored
    if ((q.st == bus_cycle_pkg::ST_DATA || q.st == bus_cycle_pkg::ST_TURN)
        && q.s2.na && !q.na_lat) begin
      d.na_lat = 1'b1;
      d.na_cnt = 2'h0;
    end else if (q.na_lat && q.na_cnt != bus_cycle_pkg::NA_MIN_CLKS) begin
      d.na_cnt = q.na_cnt + 2'h1;
    end
    // cache inputs: first of request or ready, reads only
    if (q.st == bus_cycle_pkg::ST_DATA && !q.cur.wr && !q.ken_done
        && ((q.s2.na && !q.na_lat) || q.s2.burst_ready_in)) begin
      d.ken_done = 1'b1;
      d.cache_s = q.s2.ken;
      d.wb_s = q.s2.wb;
    end
    case (q.st)
      bus_cycle_pkg::ST_IDLE: begin
        if (q.s2.hold) begin
          d.st = bus_cycle_pkg::ST_HOLD;
          d.grant = 1'b1;
          d.flt = 1'b1;
        end else if (q.drain == 2'h0) begin
          // a fresh cycle only after the idle clock
          if (q.inta == bus_cycle_pkg::INTA_SECOND) begin
            iss = '{bus_cycle_pkg::INTA2_ADDR, 1'b0, 1'b1, 1'b0,
                    1'b0, 1'b1, 1'b0};
            go = 1'b1;
          end else if (INSTR_BOUNDARY && q.smi_lat && !fifo_valid
                       && !q.smm) begin
            d.smm = 1'b1;
            d.enter = 1'b1;
            d.smi_lat = q.s2.smi;
          end else if (INSTR_BOUNDARY && q.purge_lat) begin
            d.purge_act = 1'b1;
            d.purge_wbd = 1'b0;
            d.purge_lat = q.s2.purge;
          end else if (q.purge_act && q.purge_wbd && !fifo_valid) begin
            iss = '{bus_cycle_pkg::PURGE_ACK_ADDR, 1'b1, 1'b1, 1'b0,
                    1'b0, 1'b0, 1'b0};
            go = 1'b1;
          end else if (INSTR_BOUNDARY && q.s2.irq && !q.purge_act
                       && q.inta == bus_cycle_pkg::INTA_NONE) begin
            d.inta = bus_cycle_pkg::INTA_FIRST;
            iss = '{bus_cycle_pkg::INTA1_ADDR, 1'b0, 1'b1, 1'b0,
                    1'b0, 1'b1, 1'b0};
            go = 1'b1;
          end else if (fifo_valid && (!hd[0].cyc.burst
                       || int'(fifo_cnt) >= bus_cycle_pkg::BURST_BEATS)) begin
            iss = hd[0].cyc;
            iss.fifo = 1'b1;
            if (iss.burst) begin
              iss.addr[4:0] = bus_cycle_pkg::LINE_LOW_ZERO;
            end
            go = 1'b1;
          end
        end
      end
      bus_cycle_pkg::ST_ADDR: begin
        // first data valid in the second clock
        d.st = bus_cycle_pkg::ST_DATA;
        d.doe = q.cur.wr;
        d.dout = q.cur.fifo ? hd[0].data : '0;
      end
      bus_cycle_pkg::ST_TURN: begin
        // bus floated for this clock, write data follows
        d.st = bus_cycle_pkg::ST_DATA;
        d.doe = q.cur.wr;
        d.dout = hd[0].data;
      end
      bus_cycle_pkg::ST_DATA: begin
        // second cycle only behind plain unlocked fifo cycles
        if (q.na_lat && q.na_cnt == bus_cycle_pkg::NA_MIN_CLKS && !q.nxt_v
            && q.cur.fifo && !q.cur.lock && !q.cur.burst && !q.s2.hold
            && !done && int'(fifo_cnt) >= 2 && !hd[1].cyc.burst
            && !hd[1].cyc.lock) begin
          d.nxt = hd[1].cyc;
          d.nxt.fifo = 1'b1;
          d.nxt_v = 1'b1;
          d.bus = d.nxt;
          d.addr = hd[1].cyc.addr;
          d.ads = 1'b1;
        end
        if (q.s2.burst_ready_in && !q.s2.backoff_in && !done) begin
          d.beat = q.beat + 2'h1;
          d.dout = hd[q.beat + 2'h1].data;
        end else if (done) begin
          d.beat = 2'h0;
          d.na_lat = 1'b0;
          d.ken_done = 1'b0;
          d.drain = q.cur.burst ? bus_cycle_pkg::DRAIN_BEATS : 2'h0;
          if (!q.cur.wr) begin
            d.rdata = q.s2.data;
            d.rvalid = q.inta == bus_cycle_pkg::INTA_NONE;
            d.perr = q.inta != bus_cycle_pkg::INTA_FIRST
              && par8(q.s2.data) != q.s2.par;
          end
          if (q.inta == bus_cycle_pkg::INTA_FIRST) begin
            d.inta = bus_cycle_pkg::INTA_SECOND;
          end else if (q.inta == bus_cycle_pkg::INTA_SECOND) begin
            d.inta = bus_cycle_pkg::INTA_NONE;
            d.vec = q.s2.data[7:0];
            d.vvalid = 1'b1;
          end
          if (q.cur.io && q.cur.code
              && q.smi_cnt == bus_cycle_pkg::SMI_TRAP_CLKS) begin
            d.trap = 1'b1;
          end
          if (q.cur.wr && !q.s2.ext_wbuf_empty) begin
            d.blk = 1'b1;
          end
          if (q.cur.wr && !q.cur.fifo) begin
            d.purge_act = 1'b0;
          end
          if (q.nxt_v) begin
            d.cur = q.nxt;
            d.nxt_v = 1'b0;
            if (q.nxt.wr != q.cur.wr) begin
              d.st = bus_cycle_pkg::ST_TURN;
              d.doe = 1'b0;
            end else begin
              d.dout = hd[1].data;
            end
          end else begin
            d.st = bus_cycle_pkg::ST_IDLE;
            d.doe = 1'b0;
          end
        end
      end
      bus_cycle_pkg::ST_HOLD: begin
        d.grant = q.s2.hold && !q.redo;
        if (!q.s2.hold && !q.s2.backoff_in) begin
          d.flt = 1'b0;
          d.grant = 1'b0;
          d.st = bus_cycle_pkg::ST_IDLE;
          if (q.redo) begin
            d.redo = 1'b0;
            iss = q.cur;
            go = 1'b1;
          end
        end
      end
      default: begin
        d.st = bus_cycle_pkg::ST_IDLE;
      end
    endcase
    if (go) begin
      d.cur = iss;
      d.bus = iss;
      d.addr = iss.addr;
      d.ads = 1'b1;
      d.st = bus_cycle_pkg::ST_ADDR;
      d.ken_done = 1'b0;
    end
    // back-off beats everything: float next clock, replay later
    if (q.s2.backoff_in) begin
      d.st = bus_cycle_pkg::ST_HOLD;
      d.flt = 1'b1;
      d.ads = 1'b0;
      d.doe = 1'b0;
      d.nxt_v = 1'b0;
      d.na_lat = 1'b0;
      d.beat = 2'h0;
      d.ken_done = 1'b0;
      d.redo = q.redo || go || (q.st != bus_cycle_pkg::ST_IDLE
                               && q.st != bus_cycle_pkg::ST_HOLD);
    end
    d.dpar = par8(d.dout);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      q <= bus_cycle_pkg::CTL_RESET;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------------
  assign ADDR_OUT = q.addr;
  assign ADS_N = !q.ads;
  assign MEM_IO_SEL = !q.bus.io;
  assign DATA_CODE_SEL = q.bus.code;
  assign WRITE_READ_SEL = q.bus.wr;
  assign CACHEABLE_OUT_N = !q.bus.burst;
  assign LOCK_N = !q.bus.lock;
  assign BUS_OE_N = q.flt;
  assign DATA_OUT = q.dout;
  assign DATA_PAR_OUT = q.dpar;
  assign DATA_OE_N = !q.doe;
  assign RD_DATA = q.rdata;
  assign RD_VALID = q.rvalid;
  assign RD_CACHEABLE = q.cache_s;
  assign RD_WRITEBACK = q.wb_s;
  assign PARITY_ERR = q.perr;
  assign VECTOR = q.vec;
  assign VECTOR_VALID = q.vvalid;
  assign IO_TRAP = q.trap;
  assign MGMT_ENTER = q.enter;
  assign MGMT_MODE_ACTIVE_N = !q.smm;
  assign PURGE_ACTIVE = q.purge_act;
  assign CACHE_WR_ALLOW = !q.blk;
  assign HOLD_GRANT_OUT = q.grant;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_bw_no_pipe: assert property (
    q.nxt_v |-> !q.cur.lock && !q.cur.burst)
    else $error("pipelined behind locked or burst cycle");
  chk_t2_data: assert property (
    q.st == bus_cycle_pkg::ST_ADDR && q.cur.wr && q.cur.fifo && !q.s2.backoff_in
    |=> q.doe && q.dout == $past(hd[0].data))
    else $error("first write data not valid in second clock");
  chk_wait_hold: assert property (
    q.st == bus_cycle_pkg::ST_DATA && !q.s2.burst_ready_in && !q.s2.backoff_in
    |=> $stable(q.dout) && $stable(q.doe))
    else $error("write data moved during wait state");
  chk_beat_step: assert property (
    q.st == bus_cycle_pkg::ST_DATA && q.cur.burst && q.s2.burst_ready_in
    && !q.s2.backoff_in && q.beat != bus_cycle_pkg::LAST_BEAT
    |=> q.beat == $past(q.beat) + 2'h1)
    else $error("burst beat did not advance on ready");
  chk_line_align: assert property (
    q.ads && q.bus.burst |-> q.addr[4:0] == 5'h00)
    else $error("burst write not line aligned");
  chk_bw_gap: assert property (
    done && q.cur.burst |=> !q.ads [*2])
    else $error("no idle clock after burst write");
  chk_na_space: assert property (
    $rose(q.na_lat) |-> !q.ads [*2])
    else $error("pipelined address too soon");
  chk_turn_float: assert property (
    q.st == bus_cycle_pkg::ST_TURN |-> !q.doe)
    else $error("data bus driven in turnaround");
  chk_inta_addr: assert property (
    q.ads && q.bus.lock && q.bus.io && !q.bus.code && !q.bus.wr
    |-> q.addr == (q.inta == bus_cycle_pkg::INTA_FIRST ? 32'h0000_0004
                                                       : 32'h0000_0000))
    else $error("acknowledge address wrong");
  chk_ken_skip: assert property (
    q.st == bus_cycle_pkg::ST_DATA && q.cur.wr |=> $stable(q.cache_s))
    else $error("cache input sampled in write cycle");
  chk_hold_grant: assert property (
    q.grant |-> q.flt && !q.nxt_v && !q.doe)
    else $error("grant without floated idle bus");
  chk_backoff_in_float: assert property (
    q.s2.backoff_in |=> q.flt && !q.ads && !q.doe)
    else $error("bus not floated after back-off");

  cov_burst_done: cover property (done && q.cur.burst);
  cov_pipe_issue: cover property (q.ads && q.nxt_v);
  cov_vector: cover property (q.vvalid);
  cov_hold: cover property ($rose(q.grant));
endmodule : cpu_bus_cycle_ctrl

//--- hw/bus_cycle_pkg.sv
// bus_cycle_pkg: constants and carrier types for the bus cycle controller.
// assumes a single 20 MHz system clock and a synchronous active-high reset.
package bus_cycle_pkg;

  // ------------------------------------------------------------------
  // sizes and fixed values
  // ------------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int PAR_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int BURST_BEATS = 4;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [1:0] DRAIN_BEATS = 2'h3;
  localparam logic [1:0] NA_MIN_CLKS = 2'h2;
  localparam logic [1:0] SMI_TRAP_CLKS = 2'h3;
  localparam logic [4:0] LINE_LOW_ZERO = 5'h00;
  localparam logic [31:0] INTA1_ADDR = 32'h0000_0004;
  localparam logic [31:0] INTA2_ADDR = 32'h0000_0000;
  localparam logic [31:0] PURGE_ACK_ADDR = 32'h0000_0004;
  localparam logic [1:0] INTA_NONE = 2'h0;
  localparam logic [1:0] INTA_FIRST = 2'h1;
  localparam logic [1:0] INTA_SECOND = 2'h2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h2,
    ST_TURN = 3'h3,
    ST_HOLD = 3'h4
  } bus_st_type;

  // one bus cycle as the core asks for it
  typedef struct packed {
    logic [31:0] addr;
    logic wr;
    logic io;
    logic code;
    logic burst;
    logic lock;
    logic fifo;
  } cyc_type;

  typedef struct packed {
    cyc_type cyc;
    logic [DATA_W-1:0] data;
  } req_type;

  // pin inputs, normalised to active high
  typedef struct packed {
    logic burst_ready_in;
    logic na;
    logic ken;
    logic wb;
    logic irq;
    logic smi;
    logic ext_wbuf_empty;
    logic hold;
    logic backoff_in;
    logic purge;
    logic [DATA_W-1:0] data;
    logic [PAR_W-1:0] par;
  } pin_type;

  typedef struct packed {
    pin_type s1;
    pin_type s2;
    bus_st_type st;
    cyc_type cur;
    cyc_type nxt;
    cyc_type bus;
    logic nxt_v;
    logic [1:0] beat;
    logic na_lat;
    logic [1:0] na_cnt;
    logic [1:0] drain;
    logic [31:0] addr;
    logic ads;
    logic [DATA_W-1:0] dout;
    logic [PAR_W-1:0] dpar;
    logic doe;
    logic flt;
    logic grant;
    logic redo;
    logic ken_done;
    logic cache_s;
    logic wb_s;
    logic [1:0] inta;
    logic purge_lat;
    logic purge_act;
    logic purge_wbd;
    logic smi_lat;
    logic smm;
    logic [1:0] smi_cnt;
    logic blk;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [7:0] vec;
    logic vvalid;
    logic perr;
    logic trap;
    logic enter;
  } ctl_type;

  localparam ctl_type CTL_RESET = '0;

endpackage : bus_cycle_pkg

//--- test/chipset_model.sv
// chipset_model: answers every addressed bus cycle in order, with waits.
// assumes rnd changes every clock and pins pass two sync flops inside.
`timescale 1ns/1ps
module chipset_model (
  input wire logic clk,
  input wire logic ads_n,
  input wire logic [31:0] addr,
  input wire logic wr_sel,
  input wire logic cache_n,
  input wire logic [63:0] dout,
  input wire logic [31:0] rnd,
  output logic rdy_n = 1'h1,
  output logic na_n = 1'h1,
  output logic [63:0] din = '0,
  output logic [7:0] dpar
);
  logic [33:0] cq[$];
  logic [63:0] wq[$];
  logic [31:0] aq[$];
  logic [33:0] c;
  // only the first address is on the bus; beats counted here
  // taken mid-cycle so the answering loop below never races it
  always @(negedge clk) begin
    if (ads_n === 1'h0) begin
      cq.push_back({addr, wr_sel, ~cache_n});
      aq.push_back(addr);
    end
  end
  // even parity per byte
  always_comb begin
    for (int i = 0; i < 8; i++) dpar[i] = ^din[8*i+:8];
  end
  // random waits before each ready pulse
  initial forever begin
    @(posedge clk);
    na_n <= rnd[5:3] != 3'h0;
    if (cq.size() != 0) begin
      c = cq.pop_front();
      din <= {c[33:2], ~c[33:2]};
      // one ready per beat; data set once so no beat drives it twice
      repeat (c[0] ? 4 : 1) begin
        repeat (rnd[1:0]) @(posedge clk);
        rdy_n <= 1'h0;
        @(posedge clk);
        rdy_n <= 1'h1;
        @(posedge clk);
        @(posedge clk);
        if (c[1]) wq.push_back(dout);
      end
      din <= ~din; // released bus shows no stale value
    end
  end
endmodule : chipset_model

//--- test/testbench.sv
// testbench: random reads and burst writes, acknowledge pair, bus hold.
// assumes chipset_model in test/ and the controller with its fifo.
`timescale 1ns/1ps
module testbench;
  logic CLK_SYS = 1'h0;
  logic RST = 1'h1;
  bus_cycle_pkg::req_type REQ = '0;
  logic REQ_VALID = 1'h0, INSTR_BOUNDARY = 1'h0, MASKABLE_IRQ_IN = 1'h0;
  logic CACHE_ENABLE_IN_N = 1'h1, WRITEBACK_POLICY_IN = 1'h0;
  logic EXT_WBUF_EMPTY_N = 1'h0, HOLD_REQ_IN = 1'h0;
  logic REQ_READY, RD_VALID, VECTOR_VALID, ADS_N, WRITE_READ_SEL;
  logic CACHEABLE_OUT_N, LOCK_N, BUS_OE_N, HOLD_GRANT_OUT, rdy_n, na_n;
  logic PARITY_ERR, CACHE_WR_ALLOW;
  logic [2:0] ewh = 3'h7;
  logic [63:0] RD_DATA, DATA_OUT, din;
  logic [31:0] ADDR_OUT, seed = 32'h0000FE05;
  logic [7:0] VECTOR, dpar;
  logic [63:0] rq[$], ewq[$];
  logic [31:0] eaq[$];
  int bad_count = 0;
  int total_checks = 0;
  always #25 CLK_SYS = ~CLK_SYS;
  cpu_bus_cycle_ctrl cpu_bus_cycle_ctrl_inst (.CLK_SYS(CLK_SYS), .RST(RST),
    .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .INSTR_BOUNDARY(INSTR_BOUNDARY), .RESUME_DONE(1'h0),
    .PURGE_WB_DONE(1'h0), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .RD_CACHEABLE(), .RD_WRITEBACK(), .PARITY_ERR(PARITY_ERR),
    .VECTOR(VECTOR),
    .VECTOR_VALID(VECTOR_VALID), .IO_TRAP(), .MGMT_ENTER(),
    .PURGE_ACTIVE(), .CACHE_WR_ALLOW(CACHE_WR_ALLOW), .ADDR_OUT(ADDR_OUT),
    .ADS_N(ADS_N), .MEM_IO_SEL(), .DATA_CODE_SEL(),
    .WRITE_READ_SEL(WRITE_READ_SEL), .CACHEABLE_OUT_N(CACHEABLE_OUT_N),
    .LOCK_N(LOCK_N), .BUS_OE_N(BUS_OE_N), .DATA_OUT(DATA_OUT),
    .DATA_PAR_OUT(), .DATA_OE_N(), .DATA_IN(din), .DATA_PAR_IN(dpar),
    .BURST_READY_IN_N(rdy_n), .NEXT_ADDR_REQ_N(na_n),
    .CACHE_ENABLE_IN_N(CACHE_ENABLE_IN_N),
    .WRITEBACK_POLICY_IN(WRITEBACK_POLICY_IN),
    .MASKABLE_IRQ_IN(MASKABLE_IRQ_IN), .MGMT_IRQ_IN_N(1'h1),
    .MGMT_MODE_ACTIVE_N(), .EXT_WBUF_EMPTY_N(EXT_WBUF_EMPTY_N),
    .HOLD_REQ_IN(HOLD_REQ_IN), .HOLD_GRANT_OUT(HOLD_GRANT_OUT),
    .BACKOFF_IN_N(1'h1), .CACHE_PURGE_REQ_N(1'h1));
  chipset_model chipset_model_inst (.clk(CLK_SYS), .ads_n(ADS_N),
    .addr(ADDR_OUT), .wr_sel(WRITE_READ_SEL), .cache_n(CACHEABLE_OUT_N),
    .dout(DATA_OUT), .rnd(seed), .rdy_n(rdy_n), .na_n(na_n), .din(din),
    .dpar(dpar));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [63:0] exp_rd(input logic [31:0] a);
    return {a, ~a};
  endfunction : exp_rd
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // valid held until the edge where ready is seen; caller drops it
  task automatic push(input bus_cycle_pkg::req_type r);
    REQ <= r;
    REQ_VALID <= 1'h1;
    do @(posedge CLK_SYS); while (REQ_READY !== 1'h1);
  endtask : push
  // ------------------------------------------------------------------
  // random pins and read returns
  // ------------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    seed <= xs(seed);
    CACHE_ENABLE_IN_N <= seed[7]; // ignored in burst writes
    WRITEBACK_POLICY_IN <= seed[8];
    EXT_WBUF_EMPTY_N <= seed[9];
    INSTR_BOUNDARY <= seed[10];
    if (RD_VALID === 1'h1) check(RD_DATA, rq.pop_front());
    if (RD_VALID === 1'h1) check(PARITY_ERR, 1'h0);
    // empty buffer seen three edges back must have freed cache writes
    ewh <= {ewh[1:0], EXT_WBUF_EMPTY_N};
    if (ewh[2] === 1'h0) check(CACHE_WR_ALLOW, 1'h1);
  end
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    bad_count++;
    print_verdict();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    bus_cycle_pkg::req_type r;
    logic [31:0] a;
    repeat (16) @(posedge CLK_SYS);
    RST <= 1'h0;
    @(posedge CLK_SYS);
    #1 check(ADS_N, 1'h1);
    check(HOLD_GRANT_OUT, 1'h0);
    check(REQ_READY, 1'h1);
    HOLD_REQ_IN <= 1'h1;
    for (int i = 0; i < 40 && HOLD_GRANT_OUT !== 1'h1; i++) @(posedge CLK_SYS);
    #1 check(HOLD_GRANT_OUT, 1'h1);
    check(BUS_OE_N, 1'h1);
    HOLD_REQ_IN <= 1'h0;
    repeat (6) @(posedge CLK_SYS);
    #1 check({HOLD_GRANT_OUT, BUS_OE_N}, 2'h0);
    // bursts fill the fifo until it refuses; reads mixed in at random
    for (int n = 0; n < 40; n++) begin
      a = {seed[31:3], 3'h0};
      r = '0;
      r.cyc.addr = a;
      r.cyc.io = seed[1] & ~seed[0];
      if (seed[0]) begin
        r.cyc.wr = 1'h1;
        eaq.push_back({a[31:5], 5'h00});
        for (int k = 0; k < 4; k++) begin
          r.cyc.burst = (k == 0);
          r.data = {seed, ~seed} ^ 64'(k);
          ewq.push_back(r.data);
          push(r);
        end
      end else begin
        eaq.push_back(a);
        rq.push_back(exp_rd(a));
        push(r);
      end
    end
    REQ_VALID <= 1'h0;
    for (int i = 0; i < 4000 && rq.size() != 0; i++) @(posedge CLK_SYS);
    repeat (40) @(posedge CLK_SYS);
    // acknowledge pair: addresses 4 then 0, vector from low byte
    eaq.push_back(bus_cycle_pkg::INTA1_ADDR);
    eaq.push_back(bus_cycle_pkg::INTA2_ADDR);
    MASKABLE_IRQ_IN <= 1'h1;
    for (int i = 0; i < 200 && LOCK_N !== 1'h0; i++) @(posedge CLK_SYS);
    MASKABLE_IRQ_IN <= 1'h0;
    for (int i = 0; i < 200 && VECTOR_VALID !== 1'h1; i++) @(posedge CLK_SYS);
    check(VECTOR, 8'hFF);
    repeat (20) @(posedge CLK_SYS);
    check(chipset_model_inst.wq.size(), ewq.size());
    foreach (ewq[i]) check(chipset_model_inst.wq[i], ewq[i]);
    check(chipset_model_inst.aq.size(), eaq.size());
    foreach (eaq[i]) check(chipset_model_inst.aq[i], eaq[i]);
    print_verdict();
  end
endmodule : testbench
